// File: verilog/dic_pkg.sv
package dic_pkg;

  // ****************************************************
  // Sequencer states
  // ****************************************************
  typedef enum logic [2:0] {
    ST_NC_MRZ_A    = 3'h0,
    ST_NC_PREP_A   = 3'h1,
    ST_INT_A       = 3'h2,
    ST_INT_B_MRZ_A = 3'h3,
    ST_INT_A_MRZ_B = 3'h4,
    ST_INT_B       = 3'h5,
    ST_NC_PREP_B   = 3'h6,
    ST_NC_MRZ_B    = 3'h7
  } dic_state_e;

  // ****************************************************
  // Timing counts, in internal clock periods
  // ****************************************************
  localparam int CNT_W = 12;
  // Continuous measure/reset/zero cycle
  localparam logic [11:0] MRZ_CONT_CYC = 12'h05BE;
  // Non-continuous measure/reset/zero cycle
  localparam logic [11:0] MRZ_NCONT_CYC = 12'h0B55;
  // Extra busy time when a second side must be measured
  localparam logic [11:0] MRZ_EXTRA_CYC = MRZ_NCONT_CYC - MRZ_CONT_CYC;
  // Continuous data ready delay
  localparam logic [11:0] READY_CONT_CYC = 12'h0564;
  // First and second non-continuous data ready delays
  localparam logic [11:0] READY_NC1_CYC = 12'h0563;
  localparam logic [11:0] READY_NC2_CYC = 12'h05AA;
  localparam logic [11:0] CNT_ONE = 12'h0001;
  localparam logic [11:0] CNT_ZERO = 12'h0000;

  // ****************************************************
  // Clock divider
  // ****************************************************
  localparam logic [1:0] DIV_LAST = 2'h3;
  localparam logic [1:0] DIV_ZERO = 2'h0;

  // ****************************************************
  // Status carrier
  // ****************************************************
  typedef struct packed {
    dic_state_e state;
    logic       cont_mode;
    logic       measure_busy;
    logic       integrating;
    logic       side_b_integrating;
    logic       inputs_isolated;
    logic       test_mode;
  } dic_status_s;

endpackage

// File: verilog/dic_clk_div.sv
`timescale 1ns/1ps
`default_nettype none

module dic_clk_div (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic clock_quarter_select_i,
  output logic tick_o
);

  logic [1:0] div_cnt_ff;
  logic tick_ff;

  // ****************************************************
  // Divider
  // ****************************************************
  // phase fixed at reset
  // The phase against the integrate toggle is whatever reset left it.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_cnt_ff <= dic_pkg::DIV_ZERO;
    end else begin
      div_cnt_ff <= div_cnt_ff + 2'h1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= clock_quarter_select_i ?
                 (div_cnt_ff == dic_pkg::DIV_LAST) : 1'b1;
    end
  end

  assign tick_o = tick_ff;

  // ****************************************************
  // Checks
  // ****************************************************
  a_div_quarter: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (clock_quarter_select_i && $past(clock_quarter_select_i) && tick_ff)
    ##1 clock_quarter_select_i [*2]
    |-> !$past(tick_ff) && !tick_ff ##1 !tick_ff)
    else $error("quarter divider ticked too often");

  a_div_full: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !clock_quarter_select_i |=> tick_ff)
    else $error("undivided clock missed a tick");

endmodule

`default_nettype wire

// File: verilog/dic_ctrl.sv
// Contract
// - Self-check at toggle isolates all inputs
// - Self-check rising edge injects one charge packet
// - Self-check independent of sequencing mode
// - Quarter select divides system clock by four
// - Speed select picks low power or speed
// - Result ready falls low when data ready
// - Ready timing from reset-phased divided clock
// - Active-low reset acts asynchronously
// - Integration period equals toggle interval
// - Measure two held sides, then reset
// - Fast measurement keeps continuous integration
// - Slow measurement suspends integration
// - Ready after 1380, or 1379 non-continuous
// - Start state from toggle level
// - Advance on levels, alternate sides
`timescale 1ns/1ps
`default_nettype none

module dic_ctrl (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic integrate_toggle_i,
  input wire logic self_check_i,
  input wire logic clock_quarter_select_i,
  input wire logic speed_power_select_i,
  input wire logic shift_clock_i,
  output logic result_ready_n_o,
  output logic charge_pulse_o,
  output logic high_speed_o,
  output dic_pkg::dic_status_s status_o
);

  // ****************************************************
  // Reset release and input synchronisers
  // ****************************************************
  logic rst_meta_ff, rst_sync_ff;
  logic tog_meta_ff, tog_s_ff, tog_d_ff;
  logic chk_meta_ff, chk_s_ff, chk_d_ff;
  logic qsel_meta_ff, qsel_s_ff;
  logic spd_meta_ff, spd_s_ff;
  logic sclk_meta_ff, sclk_s_ff, sclk_d_ff;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tog_meta_ff <= 1'b0;
      tog_s_ff <= 1'b0;
      chk_meta_ff <= 1'b0;
      chk_s_ff <= 1'b0;
      qsel_meta_ff <= 1'b0;
      qsel_s_ff <= 1'b0;
      spd_meta_ff <= 1'b0;
      spd_s_ff <= 1'b0;
      sclk_meta_ff <= 1'b0;
      sclk_s_ff <= 1'b0;
    end else begin
      tog_meta_ff <= integrate_toggle_i;
      tog_s_ff <= tog_meta_ff;
      chk_meta_ff <= self_check_i;
      chk_s_ff <= chk_meta_ff;
      qsel_meta_ff <= clock_quarter_select_i;
      qsel_s_ff <= qsel_meta_ff;
      spd_meta_ff <= speed_power_select_i;
      spd_s_ff <= spd_meta_ff;
      sclk_meta_ff <= shift_clock_i;
      sclk_s_ff <= sclk_meta_ff;
    end
  end

  // Delayed copies for edge detection, never of the first stage
  always_ff @(posedge core_clk_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      tog_d_ff <= 1'b0;
      chk_d_ff <= 1'b0;
      sclk_d_ff <= 1'b0;
    end else begin
      tog_d_ff <= tog_s_ff;
      chk_d_ff <= chk_s_ff;
      sclk_d_ff <= sclk_s_ff;
    end
  end

  logic tog_edge, chk_rise, sclk_fall, tick, init_ff;
  // Toggle and self-check edges wait for the sequencer start: the delayed copies reset low
  // whatever level the pins rest at, which would fake an edge
  assign tog_edge = (tog_s_ff ^ tog_d_ff) & init_ff;
  assign chk_rise = chk_s_ff & ~chk_d_ff & init_ff;
  assign sclk_fall = sclk_d_ff & ~sclk_s_ff;

  dic_clk_div u_div (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_sync_ff),
    .clock_quarter_select_i(qsel_s_ff),
    .tick_o(tick)
  );

  // ****************************************************
  // Speed and power mode
  // ****************************************************
  logic high_speed_ff;
  always_ff @(posedge core_clk_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      high_speed_ff <= 1'b0;
    end else begin
      high_speed_ff <= spd_s_ff;
    end
  end
  assign high_speed_o = high_speed_ff;

  // ****************************************************
  // Self-check
  // ****************************************************
  logic test_mode_ff, charge_pulse_ff;
  // kept apart from the sequencer so both modes see it
  always_ff @(posedge core_clk_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      test_mode_ff <= 1'b0;
    end else if (tog_edge) begin
      test_mode_ff <= chk_s_ff;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      charge_pulse_ff <= 1'b0;
    end else begin
      charge_pulse_ff <= chk_rise & test_mode_ff;
    end
  end
  assign charge_pulse_o = charge_pulse_ff;

  // ****************************************************
  // Sequencer
  // ****************************************************
  dic_pkg::dic_state_e state_ff, nxt_state;
  logic [11:0] busy_cnt_ff;
  logic busy;
  assign busy = (busy_cnt_ff != dic_pkg::CNT_ZERO);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      dic_pkg::ST_NC_MRZ_A: begin
        if (!busy) nxt_state = dic_pkg::ST_NC_PREP_A;
      end
      dic_pkg::ST_NC_PREP_A: begin
        if (tog_s_ff) nxt_state = dic_pkg::ST_INT_A;
      end
      dic_pkg::ST_INT_A: begin
        if (!tog_s_ff) nxt_state = dic_pkg::ST_INT_B_MRZ_A;
      end
      dic_pkg::ST_INT_B_MRZ_A: begin
        if (tog_s_ff) begin
          nxt_state = busy ? dic_pkg::ST_NC_MRZ_A : dic_pkg::ST_INT_A_MRZ_B;
        end
      end
      dic_pkg::ST_INT_A_MRZ_B: begin
        if (!tog_s_ff) begin
          nxt_state = busy ? dic_pkg::ST_NC_MRZ_B : dic_pkg::ST_INT_B_MRZ_A;
        end
      end
      dic_pkg::ST_INT_B: begin
        if (tog_s_ff) nxt_state = dic_pkg::ST_INT_A_MRZ_B;
      end
      dic_pkg::ST_NC_PREP_B: begin
        if (!tog_s_ff) nxt_state = dic_pkg::ST_INT_B;
      end
      dic_pkg::ST_NC_MRZ_B: begin
        if (!busy) nxt_state = dic_pkg::ST_NC_PREP_B;
      end
    endcase
  end

  logic step, into_meas, into_nc;
  assign step = tick & init_ff & (nxt_state != state_ff);
  assign into_meas = step & ((nxt_state == dic_pkg::ST_INT_B_MRZ_A) |
                             (nxt_state == dic_pkg::ST_INT_A_MRZ_B));
  assign into_nc = step & ((nxt_state == dic_pkg::ST_NC_MRZ_A) |
                           (nxt_state == dic_pkg::ST_NC_MRZ_B));

  // start state from toggle level, caught after release
  always_ff @(posedge core_clk_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      state_ff <= dic_pkg::ST_NC_MRZ_B;
      init_ff <= 1'b0;
    end else if (tick) begin
      init_ff <= 1'b1;
      if (!init_ff) begin
        state_ff <= tog_s_ff ? dic_pkg::ST_NC_MRZ_A : dic_pkg::ST_NC_MRZ_B;
      end else begin
        state_ff <= nxt_state;
      end
    end
  end

  // measure, reset, second side if stalled
  always_ff @(posedge core_clk_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      busy_cnt_ff <= dic_pkg::CNT_ZERO;
    end else if (into_meas) begin
      busy_cnt_ff <= dic_pkg::MRZ_CONT_CYC;
    end else if (into_nc) begin
      busy_cnt_ff <= busy_cnt_ff + dic_pkg::MRZ_EXTRA_CYC;
    end else if (tick && busy) begin
      busy_cnt_ff <= busy_cnt_ff - dic_pkg::CNT_ONE;
    end
  end

  // ****************************************************
  // Result ready
  // ****************************************************
  logic [11:0] rdy_cnt_ff;
  logic second_ff, ready_n_ff, rdy_fire;
  assign rdy_fire = tick & ~into_meas & ~into_nc &
                    (rdy_cnt_ff == dic_pkg::CNT_ONE);

  always_ff @(posedge core_clk_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      rdy_cnt_ff <= dic_pkg::CNT_ZERO;
      second_ff <= 1'b0;
    end else if (into_meas) begin
      rdy_cnt_ff <= dic_pkg::READY_CONT_CYC;
      second_ff <= 1'b0;
    end else if (into_nc) begin
      rdy_cnt_ff <= dic_pkg::READY_NC1_CYC;
      second_ff <= 1'b1;
    end else if (rdy_fire && second_ff) begin
      rdy_cnt_ff <= dic_pkg::READY_NC2_CYC;
      second_ff <= 1'b0;
    end else if (tick && rdy_cnt_ff != dic_pkg::CNT_ZERO) begin
      rdy_cnt_ff <= rdy_cnt_ff - dic_pkg::CNT_ONE;
    end
  end

  // low until shift clock cycles; a new result wins
  always_ff @(posedge core_clk_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      ready_n_ff <= 1'b1;
    end else if (rdy_fire) begin
      ready_n_ff <= 1'b0;
    end else if (sclk_fall) begin
      ready_n_ff <= 1'b1;
    end
  end
  assign result_ready_n_o = ready_n_ff;

  // ****************************************************
  // Status
  // ****************************************************
  logic cont;
  assign cont = (state_ff == dic_pkg::ST_INT_A) |
                (state_ff == dic_pkg::ST_INT_B_MRZ_A) |
                (state_ff == dic_pkg::ST_INT_A_MRZ_B) |
                (state_ff == dic_pkg::ST_INT_B);

  // integrating between toggles
  // Non-continuous states ground the inputs as well
  always_comb begin
    status_o.state = state_ff;
    status_o.cont_mode = cont;
    status_o.measure_busy = busy;
    status_o.integrating = cont;
    status_o.side_b_integrating = (state_ff == dic_pkg::ST_INT_B) |
                                  (state_ff == dic_pkg::ST_INT_B_MRZ_A);
    status_o.inputs_isolated = test_mode_ff | ~cont;
    status_o.test_mode = test_mode_ff;
  end

  // ****************************************************
  // Checks
  // ****************************************************
  a_iso_on_check: assert property (
    @(posedge core_clk_i) disable iff (!rst_sync_ff)
    (tog_edge && chk_s_ff) |=> status_o.inputs_isolated)
    else $error("self-check at toggle did not isolate inputs");

  a_inject_edge: assert property (
    @(posedge core_clk_i) disable iff (!rst_sync_ff)
    (chk_rise && test_mode_ff) |=> charge_pulse_ff ##1 !charge_pulse_ff)
    else $error("charge packet pulse wrong");

  a_no_inject_off: assert property (
    @(posedge core_clk_i) disable iff (!rst_sync_ff)
    !$past(test_mode_ff) |-> !charge_pulse_ff)
    else $error("charge packet outside self-check");

  a_prep_to_int: assert property (
    @(posedge core_clk_i) disable iff (!rst_sync_ff)
    (state_ff == dic_pkg::ST_NC_PREP_A && tick && init_ff && tog_s_ff)
    |=> state_ff == dic_pkg::ST_INT_A)
    else $error("prepared side A did not start integrating");

  a_cont_step: assert property (
    @(posedge core_clk_i) disable iff (!rst_sync_ff)
    (state_ff == dic_pkg::ST_INT_B_MRZ_A && tick && init_ff &&
     tog_s_ff && !busy) |=> state_ff == dic_pkg::ST_INT_A_MRZ_B)
    else $error("continuous step lost");

  a_ncont_step: assert property (
    @(posedge core_clk_i) disable iff (!rst_sync_ff)
    (state_ff == dic_pkg::ST_INT_A_MRZ_B && tick && init_ff &&
     !tog_s_ff && busy) |=> state_ff == dic_pkg::ST_NC_MRZ_B)
    else $error("busy toggle did not suspend integration");

  a_meas_load: assert property (
    @(posedge core_clk_i) disable iff (!rst_sync_ff)
    into_meas |=> rdy_cnt_ff == dic_pkg::READY_CONT_CYC &&
                  busy_cnt_ff == dic_pkg::MRZ_CONT_CYC)
    else $error("measure counters not loaded");

  a_ready_fall: assert property (
    @(posedge core_clk_i) disable iff (!rst_sync_ff)
    rdy_fire |=> !result_ready_n_o)
    else $error("result ready did not fall");

  a_speed_follow: assert property (
    @(posedge core_clk_i) disable iff (!rst_sync_ff)
    $past(rst_sync_ff) |-> high_speed_o == $past(spd_s_ff))
    else $error("speed mode not following select");

  a_rst_quiet: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    !rst_sync_ff |-> result_ready_n_o && !charge_pulse_o)
    else $error("outputs active before reset release");

endmodule

`default_nettype wire

// File: tb/dic_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module dic_host_model (
  input wire logic core_clk_i,
  input wire logic result_ready_n_i,
  output logic integrate_toggle_o,
  output logic self_check_o,
  output logic shift_clock_o
);
  // *****************************
  // Host pins
  // *****************************
  // Shift clock parked low
  initial begin
    integrate_toggle_o = 1'b0;
    self_check_o = 1'b0;
    shift_clock_o = 1'b0;
  end

  task automatic step(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic toggle(input logic lvl);
    step(1);
    integrate_toggle_o = lvl;
  endtask

  task automatic set_check(input logic lvl);
    self_check_o = lvl;
    step(10);
  endtask

  // Phases of one microsecond
  // Rise ends 1 us ahead of any later toggle
  task automatic strobe_check();
    self_check_o = 1'b0;
    step(10);
    self_check_o = 1'b1;
    step(10);
  endtask

  task automatic read_out();
    shift_clock_o = 1'b1;
    step(4);
    shift_clock_o = 1'b0;
    step(6);
  endtask

  task automatic wait_ready(input int limit, output int n);
    n = 0;
    while (result_ready_n_i !== 1'b0 && n < limit) begin
      step(1);
      n++;
    end
  endtask
endmodule

`default_nettype wire

// File: tb/test_dual_integrator_conversion_control.sv
`timescale 1ns/1ps
`default_nettype none

module test_dual_integrator_conversion_control;
  logic core_clk_i;
  logic reset_n_i;
  logic quarter;
  logic speed;
  logic toggle;
  logic chk;
  logic sclk;
  logic ready_n;
  logic pulse;
  logic hs;
  dic_pkg::dic_status_s st;
  int fail_count = 0;
  int tests_run = 0;
  int pulses = 0;
  int n;

  // *****************************
  // Clock, design and host
  // *****************************
  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  dic_ctrl DUT (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .integrate_toggle_i(toggle),
    .self_check_i(chk),
    .clock_quarter_select_i(quarter),
    .speed_power_select_i(speed),
    .shift_clock_i(sclk),
    .result_ready_n_o(ready_n),
    .charge_pulse_o(pulse),
    .high_speed_o(hs),
    .status_o(st)
  );

  dic_host_model host (
    .core_clk_i(core_clk_i),
    .result_ready_n_i(ready_n),
    .integrate_toggle_o(toggle),
    .self_check_o(chk),
    .shift_clock_o(sclk)
  );

  always @(posedge core_clk_i) begin
    if (pulse === 1'b1) begin
      pulses++;
    end
  end

  // *****************************
  // Checking
  // *****************************
  function automatic logic [15:0] ext(input logic v);
    return {15'h0000, v};
  endfunction

  function automatic logic [15:0] ext3(input logic [2:0] v);
    return {13'h0000, v};
  endfunction

  function automatic logic [15:0] inr(input int v, input int lo,
                                      input int hi);
    return {15'h0000, (v >= lo) && (v <= hi)};
  endfunction

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Whole run is near 18100 cycles; this leaves ample margin
  initial begin
    repeat (60000) @(posedge core_clk_i);
    fail_count++;
    give_verdict();
  end

  // *****************************
  // Sequence
  // *****************************
  initial begin
    reset_n_i = 1'b0;
    quarter = 1'b0;
    speed = 1'b0;
    repeat (12) @(posedge core_clk_i);
    #1;
    check("rst ready", ext(ready_n), 16'h0001);
    check("rst pulse", ext(pulse), 16'h0000);
    check("rst speed", ext(hs), 16'h0000);
    check("rst state", ext3(st.state), ext3(dic_pkg::ST_NC_MRZ_B));
    reset_n_i = 1'b1;
    speed = 1'b1;
    host.step(10);
    check("start", ext3(st.state), ext3(dic_pkg::ST_INT_B));
    check("speed hi", ext(hs), 16'h0001);
    // Continuous: 6 -> 5, then 5 -> 4
    host.toggle(1'b1);
    host.step(5);
    check("st5", ext3(st.state), ext3(dic_pkg::ST_INT_A_MRZ_B));
    check("cont", ext(st.cont_mode), 16'h0001);
    check("busy", ext(st.measure_busy), 16'h0001);
    check("iso", ext(st.inputs_isolated), 16'h0000);
    check("integ", ext(st.integrating), 16'h0001);
    host.wait_ready(2000, n);
    check("t cont", inr(n + 5, 1381, 1386), 16'h0001);
    host.step(20);
    check("rdy holds", ext(ready_n), 16'h0000);
    host.read_out();
    check("rdy clear", ext(ready_n), 16'h0001);
    speed = 1'b0;
    host.step(100);
    check("speed lo", ext(hs), 16'h0000);
    host.toggle(1'b0);
    host.step(5);
    check("st4", ext3(st.state), ext3(dic_pkg::ST_INT_B_MRZ_A));
    check("side b", ext(st.side_b_integrating), 16'h0001);
    host.wait_ready(2000, n);
    check("t cont2", inr(n + 5, 1381, 1386), 16'h0001);
    host.read_out();
    // Toggle while still busy forces non-continuous state 1
    host.toggle(1'b1);
    host.step(5);
    check("st1", ext3(st.state), ext3(dic_pkg::ST_NC_MRZ_A));
    check("ncont", ext(st.cont_mode), 16'h0000);
    check("nc iso", ext(st.inputs_isolated), 16'h0001);
    host.wait_ready(2000, n);
    check("t nc1", inr(n + 5, 1380, 1386), 16'h0001);
    host.read_out();
    host.wait_ready(2000, n);
    check("t nc2", inr(n + 10, 1449, 1452), 16'h0001);
    host.read_out();
    host.step(100);
    check("st3", ext3(st.state), ext3(dic_pkg::ST_INT_A));
    // Quarter select stretches every count by four
    quarter = 1'b1;
    host.step(10);
    host.toggle(1'b0);
    host.wait_ready(7000, n);
    check("t quarter", inr(n, 5518, 5530), 16'h0001);
    host.read_out();
    quarter = 1'b0;
    host.step(400);
    // Self-check rise outside test mode gives no packet
    host.set_check(1'b1);
    check("no pkt", pulses[15:0], 16'h0000);
    host.toggle(1'b1);
    host.step(5);
    check("test", ext(st.test_mode), 16'h0001);
    check("t iso", ext(st.inputs_isolated), 16'h0001);
    host.strobe_check();
    host.strobe_check();
    check("pkts", pulses[15:0], 16'h0002);
    host.wait_ready(2000, n);
    check("t test", inr(n + 45, 1381, 1386), 16'h0001);
    host.read_out();
    check("t clear", ext(ready_n), 16'h0001);
    host.set_check(1'b0);
    host.step(100);
    host.toggle(1'b0);
    host.step(5);
    check("test off", ext(st.test_mode), 16'h0000);
    check("st4 b", ext3(st.state), ext3(dic_pkg::ST_INT_B_MRZ_A));
    // Reset in mid-run while a result is pending
    host.wait_ready(2000, n);
    reset_n_i = 1'b0;
    #20;
    check("async rdy", ext(ready_n), 16'h0001);
    check("async busy", ext(st.measure_busy), 16'h0000);
    host.toggle(1'b1);
    host.step(500);
    reset_n_i = 1'b1;
    host.step(10);
    check("restart", ext3(st.state), ext3(dic_pkg::ST_INT_A));
    // Busy toggle from state 5 suspends into state 8
    host.toggle(1'b0);
    host.step(1500);
    host.read_out();
    host.toggle(1'b1);
    host.step(5);
    check("st5 b", ext3(st.state), ext3(dic_pkg::ST_INT_A_MRZ_B));
    host.toggle(1'b0);
    host.step(5);
    check("st8", ext3(st.state), ext3(dic_pkg::ST_NC_MRZ_B));
    check("nc integ", ext(st.integrating), 16'h0000);
    host.wait_ready(2000, n);
    check("t nc1 b", inr(n + 5, 1380, 1386), 16'h0001);
    give_verdict();
  end
endmodule

`default_nettype wire
